// file: rtl/sei_pkg.sv
/*
 * Shared constants and types for both ends of the serial EEPROM bus link.
 * Assumes both ends run on the same 100 MHz system clock.
 */
package sei_pkg;

	// ********************************
	// Data and array geometry
	// ********************************
	localparam int          SEI_BYTE_W      = 8;
	localparam int          SEI_BIT_CNT_W   = 3;
	localparam int          SEI_ADDR_W      = 17;
	localparam int          SEI_ARRAY_BYTES = 131072;
	localparam int          SEI_PAGES       = 512;
	localparam int          SEI_PAGE_BYTES  = 256;

	// ********************************
	// Protected region start per block-protect code
	// ********************************
	localparam logic [16:0] SEI_PROT_QUARTER = 17'h18000;
	localparam logic [16:0] SEI_PROT_HALF    = 17'h10000;
	localparam logic [16:0] SEI_PROT_WHOLE   = 17'h00000;
	localparam logic [1:0]  SEI_BP_RESET     = 2'h0;
	localparam logic [1:0]  SEI_BP_NONE      = 2'h0;
	localparam logic [1:0]  SEI_BP_QUARTER   = 2'h1;
	localparam logic [1:0]  SEI_BP_HALF      = 2'h2;

	// ********************************
	// Timing
	// ********************************
	localparam int          SEI_CLK_PERIOD_NS = 10;
	localparam int          SEI_SCK_HALF_NS   = 60;
	localparam int          SEI_SCK_HALF_CYC  = (SEI_SCK_HALF_NS + SEI_CLK_PERIOD_NS - 1)
		/ SEI_CLK_PERIOD_NS;
	localparam logic [3:0]  SEI_HALF_LAST     = 4'(SEI_SCK_HALF_CYC - 1);
	localparam logic [3:0]  SEI_PHASE_LAST    = 4'hF;

	// ********************************
	// Master sequencer states
	// ********************************
	typedef enum logic [2:0] {
		SEI_H_IDLE,
		SEI_H_LEAD,
		SEI_H_SHIFT,
		SEI_H_GAP,
		SEI_H_TRAIL
	} sei_host_state_t;

endpackage

// file: rtl/sei_link_if.sv
/*
 * Serial bus wires between the bus master end and the memory end.
 * Assumes a pull-up on the data output line when the memory does not drive it.
 */
interface sei_link_if;
	logic sclk;
	logic mosi;
	logic cs_n;
	logic hold_n;
	logic wp_n;
	logic q;
	logic q_oe_n;
	logic miso;

	// Released line reads high through the pull-up.
	assign miso = q_oe_n ? 1'b1 : q;

	modport mem (
		input  sclk,
		input  mosi,
		input  cs_n,
		input  hold_n,
		input  wp_n,
		output q,
		output q_oe_n
	);

	modport master (
		output sclk,
		output mosi,
		output cs_n,
		output hold_n,
		output wp_n,
		input  miso
	);
endinterface

// file: rtl/sei_mem_end.sv
/*
 * Memory end of the serial bus: bit assembly, read data shifting, select,
 * pause and write-protect handling, all oversampled on the system clock.
 * Assumes the serial clock is far slower than the system clock.
 */

// Summary of operation
// R1: Output bits change on serial clock falling edges.
// R2: Input bits captured on serial clock rising edges.
// R3: Deselected means output released to high impedance.
// R4: Standby when deselected and no write busy.
// R5: Ignore traffic until first select falling edge.
// R6: Pause suspends transfer, keeps bit position.
// R7: Paused: output released, clock and data ignored.
// R8: Pause entered only while selected.
// R9: Write-protect low freezes block-protect bits.
// R10: Master keeps write-protect stable during writes.
// R11: Bytes sent and assembled MSB first.
// R12: First bit on first rise after select.
// R13: Output bytes sent MSB first.
// R14: Read data starts at first fall after byte.
// R15: Works in clock modes 0 and 3.
// R16: Master parks clock at its polarity level.
// R17: Array is 131072 bytes, 512 pages of 256.
// R18: Master selects only one device at once.
// R19: Pause begins when pause falls, clock low.
// R20: Pause ends when pause rises, clock low.
// R21: Deselect while paused resets interface state.
// R22: Output released whenever not sending read data.
module sei_mem_end
	import sei_pkg::*;
(
	// Clock and reset
	input  wire logic                    CLK_SYS,
	input  wire logic                    RST_B,
	// Serial link
	sei_link_if.mem                      LINK,
	// Received bytes
	output logic                         RX_VALID,
	output logic [SEI_BYTE_W-1:0]        RX_DATA,
	output logic                         RX_FIRST,
	// Read data to send
	input  wire logic                    TX_EN,
	input  wire logic [SEI_BYTE_W-1:0]   TX_DATA,
	// Protection
	input  wire logic                    BP_WR,
	input  wire logic [1:0]              BP_WR_DATA,
	output logic [1:0]                   BLOCK_PROTECT,
	output logic [SEI_ADDR_W-1:0]        PROT_BASE,
	output logic                         PROT_ANY,
	// Status
	input  wire logic                    WRITE_BUSY,
	output logic                         SELECTED,
	output logic                         HOLDING,
	output logic                         STANDBY
);

	// ********************************
	// Pin synchronisers
	// ********************************
	// Bit order: wp_n, hold_n, cs_n, mosi, sclk.
	logic [4:0]                  pin_s1_r;
	logic [4:0]                  pin_s2_r;
	logic [4:0]                  pin_s3_r;

	// The chain follows the pins through reset as well. A select line that is
	// already low when reset ends then shows no false falling edge.
	always_ff @(posedge CLK_SYS) begin
		pin_s1_r <= {LINK.wp_n, LINK.hold_n, LINK.cs_n, LINK.mosi, LINK.sclk};
		pin_s2_r <= pin_s1_r;
		pin_s3_r <= pin_s2_r;
	end

	logic                        sclk_s;
	logic                        mosi_s;
	logic                        cs_n_s;
	logic                        hold_n_s;
	logic                        wp_n_s;
	logic                        sclk_rise;
	logic                        sclk_fall;
	logic                        cs_fall;
	logic                        hold_edge;

	assign sclk_s    = pin_s2_r[0];
	assign mosi_s    = pin_s2_r[1];
	assign cs_n_s    = pin_s2_r[2];
	assign hold_n_s  = pin_s2_r[3];
	assign wp_n_s    = pin_s2_r[4];
	assign sclk_rise = sclk_s & ~pin_s3_r[0];
	assign sclk_fall = ~sclk_s & pin_s3_r[0];
	assign cs_fall   = ~cs_n_s & pin_s3_r[2];
	assign hold_edge = hold_n_s ^ pin_s3_r[3];

	// ********************************
	// Serial engine
	// ********************************
	logic                        armed_r, armed_nxt;
	logic                        hold_r, hold_nxt;
	logic [SEI_BIT_CNT_W-1:0]    bit_cnt_r, bit_cnt_nxt;
	logic [SEI_BYTE_W-1:0]       rx_sh_r, rx_sh_nxt;
	logic                        first_r, first_nxt;
	logic                        byte_done_r, byte_done_nxt;
	logic                        send_r, send_nxt;
	logic [SEI_BYTE_W-1:0]       tx_sh_r, tx_sh_nxt;
	logic                        q_r, q_nxt;
	logic                        oe_r, oe_nxt;
	logic                        rx_valid_r, rx_valid_nxt;
	logic [SEI_BYTE_W-1:0]       rx_data_r, rx_data_nxt;
	logic                        rx_first_r, rx_first_nxt;
	logic                        active;

	// Clock edges count only when selected, armed and not paused.
	assign active = ~cs_n_s & armed_r & ~hold_r; // R5 R7

	always_comb begin
		armed_nxt     = armed_r;
		hold_nxt      = hold_r;
		bit_cnt_nxt   = bit_cnt_r;
		rx_sh_nxt     = rx_sh_r;
		first_nxt     = first_r;
		byte_done_nxt = byte_done_r;
		send_nxt      = send_r;
		tx_sh_nxt     = tx_sh_r;
		q_nxt         = q_r;
		oe_nxt        = oe_r;
		rx_valid_nxt  = 1'b0;
		rx_data_nxt   = rx_data_r;
		rx_first_nxt  = rx_first_r;
		if (cs_fall) begin
			armed_nxt = 1'b1; // R5
		end
		if (cs_n_s) begin
			// Deselect abandons everything, paused or not.
			hold_nxt      = 1'b0; // R21
			bit_cnt_nxt   = '0; // R21
			first_nxt     = 1'b1;
			byte_done_nxt = 1'b0;
			send_nxt      = 1'b0;
			oe_nxt        = 1'b0; // R3
		end else begin
			if (armed_r && ((hold_edge && !sclk_s) || sclk_fall)) begin
				hold_nxt = ~hold_n_s; // R6 R8 R19 R20
			end
			if (active && sclk_rise) begin
				rx_sh_nxt   = {rx_sh_r[SEI_BYTE_W-2:0], mosi_s}; // R2 R11 R12 R15
				bit_cnt_nxt = bit_cnt_r + 3'h1;
				if (bit_cnt_r == 3'h7) begin
					rx_valid_nxt  = 1'b1;
					rx_data_nxt   = {rx_sh_r[SEI_BYTE_W-2:0], mosi_s}; // R11
					rx_first_nxt  = first_r;
					first_nxt     = 1'b0;
					byte_done_nxt = 1'b1;
				end
			end
			if (active && sclk_fall) begin
				if (byte_done_r) begin
					// Byte boundary: start or stop read data.
					byte_done_nxt = 1'b0;
					send_nxt      = TX_EN;
					q_nxt         = TX_DATA[SEI_BYTE_W-1]; // R13 R14
					tx_sh_nxt     = {TX_DATA[SEI_BYTE_W-2:0], 1'b0};
					oe_nxt        = TX_EN; // R22
				end else begin
					q_nxt     = tx_sh_r[SEI_BYTE_W-1]; // R1 R13 R15
					tx_sh_nxt = {tx_sh_r[SEI_BYTE_W-2:0], 1'b0};
					oe_nxt    = send_r; // R22
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			armed_r     <= 1'b0;
			hold_r      <= 1'b0;
			bit_cnt_r   <= '0;
			rx_sh_r     <= '0;
			first_r     <= 1'b1;
			byte_done_r <= 1'b0;
			send_r      <= 1'b0;
			tx_sh_r     <= '0;
			q_r         <= 1'b0;
			oe_r        <= 1'b0;
			rx_valid_r  <= 1'b0;
			rx_data_r   <= '0;
			rx_first_r  <= 1'b0;
		end else begin
			armed_r     <= armed_nxt;
			hold_r      <= hold_nxt;
			bit_cnt_r   <= bit_cnt_nxt;
			rx_sh_r     <= rx_sh_nxt;
			first_r     <= first_nxt;
			byte_done_r <= byte_done_nxt;
			send_r      <= send_nxt;
			tx_sh_r     <= tx_sh_nxt;
			q_r         <= q_nxt;
			oe_r        <= oe_nxt;
			rx_valid_r  <= rx_valid_nxt;
			rx_data_r   <= rx_data_nxt;
			rx_first_r  <= rx_first_nxt;
		end
	end

	// ********************************
	// Block protection
	// ********************************
	logic [1:0]                  bp_r, bp_nxt;

	always_comb begin
		bp_nxt = bp_r;
		if (BP_WR && wp_n_s) begin
			bp_nxt = BP_WR_DATA; // R9
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			bp_r <= SEI_BP_RESET;
		end else begin
			bp_r <= bp_nxt;
		end
	end

	always_comb begin
		unique case (bp_r)
			SEI_BP_QUARTER: PROT_BASE = SEI_PROT_QUARTER; // R17
			SEI_BP_HALF:    PROT_BASE = SEI_PROT_HALF;
			default:        PROT_BASE = SEI_PROT_WHOLE;
		endcase
	end

	// ********************************
	// Outputs
	// ********************************
	assign LINK.q        = q_r;
	assign LINK.q_oe_n   = ~(oe_r & ~hold_r & ~cs_n_s); // R3 R7 R22
	assign RX_VALID      = rx_valid_r;
	assign RX_DATA       = rx_data_r;
	assign RX_FIRST      = rx_first_r;
	assign BLOCK_PROTECT = bp_r;
	assign PROT_ANY      = (bp_r != SEI_BP_NONE);
	assign SELECTED      = ~cs_n_s & armed_r;
	assign HOLDING       = hold_r;
	assign STANDBY       = cs_n_s & ~WRITE_BUSY; // R4

endmodule

// file: rtl/sei_master_end.sv
/*
 * Bus master end: generates the serial clock by division, shifts command
 * bytes out and read bytes in, drives select, pause and write-protect.
 * Assumes a single memory device on the select line.
 */
module sei_master_end
	import sei_pkg::*;
(
	// Clock and reset
	input  wire logic                    CLK_SYS,
	input  wire logic                    RST_B,
	// Serial link
	sei_link_if.master                   LINK,
	// Configuration
	input  wire logic                    CPOL_1,
	input  wire logic                    WP_LEVEL,
	input  wire logic                    HOLD_REQ,
	// Byte commands
	input  wire logic                    CMD_VALID,
	output logic                         CMD_READY,
	input  wire logic [SEI_BYTE_W-1:0]   CMD_DATA,
	input  wire logic                    CMD_LAST,
	// Byte answers
	output logic                         RSP_VALID,
	output logic [SEI_BYTE_W-1:0]        RSP_DATA,
	output logic                         BUSY
);

	logic                        miso_s1_r;
	logic                        miso_s2_r;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			miso_s1_r <= 1'b1;
			miso_s2_r <= 1'b1;
		end else begin
			miso_s1_r <= LINK.miso;
			miso_s2_r <= miso_s1_r;
		end
	end

	// ********************************
	// Sequencer
	// ********************************
	sei_host_state_t             state_r, state_nxt;
	logic [3:0]                  div_r, div_nxt;
	logic [3:0]                  phase_r, phase_nxt;
	logic [SEI_BYTE_W-1:0]       sh_r, sh_nxt;
	logic                        last_r, last_nxt;
	logic                        cpol_r, cpol_nxt;
	logic                        sclk_r, sclk_nxt;
	logic                        mosi_r, mosi_nxt;
	logic                        cs_n_r, cs_n_nxt;
	logic                        hold_n_r, hold_n_nxt;
	logic                        wp_n_r, wp_n_nxt;
	logic                        rsp_valid_r, rsp_valid_nxt;
	logic [SEI_BYTE_W-1:0]       rsp_data_r, rsp_data_nxt;
	logic                        div_end;

	assign div_end   = (div_r == SEI_HALF_LAST);
	assign CMD_READY = ((state_r == SEI_H_IDLE) || (state_r == SEI_H_GAP)) && hold_n_r
		&& !HOLD_REQ;

	always_comb begin
		state_nxt     = state_r;
		div_nxt       = div_end ? 4'h0 : div_r + 4'h1;
		phase_nxt     = phase_r;
		sh_nxt        = sh_r;
		last_nxt      = last_r;
		cpol_nxt      = cpol_r;
		sclk_nxt      = sclk_r;
		mosi_nxt      = mosi_r;
		cs_n_nxt      = cs_n_r;
		hold_n_nxt    = hold_n_r;
		wp_n_nxt      = wp_n_r;
		rsp_valid_nxt = 1'b0;
		rsp_data_nxt  = rsp_data_r;
		unique case (state_r)
			SEI_H_IDLE: begin
				cpol_nxt = CPOL_1;
				sclk_nxt = CPOL_1; // R16
				wp_n_nxt = WP_LEVEL; // R10
				if (CMD_VALID && CMD_READY) begin
					// Select falls from a high idle level before any command.
					cs_n_nxt  = 1'b0; // R5 R18
					sh_nxt    = CMD_DATA;
					last_nxt  = CMD_LAST;
					div_nxt   = 4'h0;
					state_nxt = SEI_H_LEAD;
				end
			end
			SEI_H_LEAD: begin
				if (div_end) begin
					phase_nxt = 4'h0;
					sclk_nxt  = 1'b0;
					mosi_nxt  = sh_r[SEI_BYTE_W-1]; // R11
					sh_nxt    = {sh_r[SEI_BYTE_W-2:0], 1'b0};
					state_nxt = SEI_H_SHIFT;
				end
			end
			SEI_H_SHIFT: begin
				if (div_end) begin
					phase_nxt = phase_r + 4'h1;
					if (!phase_r[0]) begin
						sclk_nxt = 1'b1; // R15
					end else begin
						// End of high phase: device output has long settled.
						rsp_data_nxt = {rsp_data_r[SEI_BYTE_W-2:0], miso_s2_r}; // R13
						if (phase_r == SEI_PHASE_LAST) begin
							sclk_nxt      = cpol_r; // R16
							rsp_valid_nxt = 1'b1;
							state_nxt     = last_r ? SEI_H_TRAIL : SEI_H_GAP;
						end else begin
							sclk_nxt = 1'b0;
							mosi_nxt = sh_r[SEI_BYTE_W-1]; // R11
							sh_nxt   = {sh_r[SEI_BYTE_W-2:0], 1'b0};
						end
					end
				end
			end
			SEI_H_GAP: begin
				// Pause only with select low and the clock parked low.
				if (!cpol_r) begin
					hold_n_nxt = ~HOLD_REQ; // R8 R19 R20
				end
				if (CMD_VALID && CMD_READY) begin
					sh_nxt    = CMD_DATA;
					last_nxt  = CMD_LAST;
					div_nxt   = 4'h0;
					state_nxt = SEI_H_LEAD;
				end
			end
			SEI_H_TRAIL: begin
				if (div_end) begin
					cs_n_nxt  = 1'b1;
					state_nxt = SEI_H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			state_r     <= SEI_H_IDLE;
			div_r       <= 4'h0;
			phase_r     <= 4'h0;
			sh_r        <= '0;
			last_r      <= 1'b0;
			cpol_r      <= 1'b0;
			sclk_r      <= 1'b0;
			mosi_r      <= 1'b0;
			cs_n_r      <= 1'b1;
			hold_n_r    <= 1'b1;
			wp_n_r      <= 1'b1;
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= '0;
		end else begin
			state_r     <= state_nxt;
			div_r       <= div_nxt;
			phase_r     <= phase_nxt;
			sh_r        <= sh_nxt;
			last_r      <= last_nxt;
			cpol_r      <= cpol_nxt;
			sclk_r      <= sclk_nxt;
			mosi_r      <= mosi_nxt;
			cs_n_r      <= cs_n_nxt;
			hold_n_r    <= hold_n_nxt;
			wp_n_r      <= wp_n_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_data_r  <= rsp_data_nxt;
		end
	end

	assign LINK.sclk   = sclk_r;
	assign LINK.mosi   = mosi_r;
	assign LINK.cs_n   = cs_n_r;
	assign LINK.hold_n = hold_n_r;
	assign LINK.wp_n   = wp_n_r;
	assign RSP_VALID   = rsp_valid_r;
	assign RSP_DATA    = rsp_data_r;
	assign BUSY        = (state_r != SEI_H_IDLE);

endmodule

// file: test/sei_link_properties.sv
/*
 * Checker on the serial link wires between the master end and the memory end.
 * Assumes it is instantiated beside the link interface in the bench top.
 */
module sei_link_properties (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// Link wires
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cs_n,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic q,
	input wire logic q_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;

	// ********************************
	// Properties
	// ********************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	deselect_release_a: assert property (cs_n [*4] |-> q_oe_n)
		else $error("data output driven while deselected");
	out_on_fall_a: assert property (($changed(q) && !q_oe_n) |-> (!sclk && !$past(sclk, 2)))
		else $error("data output changed outside a clock low phase");
	pause_release_a: assert property ((!hold_n && !sclk) [*5] |-> q_oe_n)
		else $error("data output driven while paused");
	sample_setup_a: assert property ($rose(sclk) |-> $stable(mosi))
		else $error("data input moved at a sampling edge");
	first_edge_gap_a: assert property ($fell(cs_n) |-> $stable(sclk) [*5])
		else $error("clock moved right at selection");
	idle_park_a: assert property ($rose(cs_n) |-> sclk == $past(sclk, 5))
		else $error("clock not parked before deselection");
	wp_steady_a: assert property ((!cs_n && !$past(cs_n)) |-> $stable(wp_n))
		else $error("write protect moved while selected");
	read_start_a: assert property (($fell(q_oe_n) && $past(hold_n, 4)) |->
		(!cs_n && !sclk && $past(sclk, 5)))
		else $error("read data started off a falling clock edge");

	cover property ($fell(q_oe_n));
	cover property (!hold_n && !cs_n);
	cover property ($rose(cs_n) && sclk);
endmodule

// file: test/tb_serial_eeprom_bus_interface.sv
/*
 * Self-checking bench: master end and memory end face each other on one link,
 * a second memory end is driven by hand to break the master's side of the rules.
 * Assumes the design files of rtl/ are compiled first.
 */
module tb_serial_eeprom_bus_interface
	import sei_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk_sys, rst_b, cpol_1, wp_level, hold_req;
	logic        cmd_valid, cmd_ready, cmd_last, rsp_valid, busy;
	logic        rx_valid, rx_first, tx_en, bp_wr, prot_any, write_busy;
	logic        selected, standby, holding, rx2_valid, sel2, hold2;
	logic [7:0]  cmd_data, rsp_data, rx_data, tx_data, rx2_data;
	logic [1:0]  bp_wr_data, block_protect;
	logic [16:0] prot_base;
	logic [8:0]  rxq[$];
	int          rx2_cnt, error_cnt, n_checks;

	sei_link_if link ();
	sei_link_if link_b ();

	sei_master_end sei_master_end_inst (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(link.master),
		.CPOL_1(cpol_1), .WP_LEVEL(wp_level), .HOLD_REQ(hold_req),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_DATA(cmd_data),
		.CMD_LAST(cmd_last), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .BUSY(busy));
	sei_mem_end sei_mem_end_inst (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(link.mem),
		.RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_FIRST(rx_first),
		.TX_EN(tx_en), .TX_DATA(tx_data), .BP_WR(bp_wr), .BP_WR_DATA(bp_wr_data),
		.BLOCK_PROTECT(block_protect), .PROT_BASE(prot_base), .PROT_ANY(prot_any),
		.WRITE_BUSY(write_busy), .SELECTED(selected), .HOLDING(holding), .STANDBY(standby));
	sei_mem_end sei_mem_end_b_inst (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(link_b.mem),
		.RX_VALID(rx2_valid), .RX_DATA(rx2_data), .RX_FIRST(),
		.TX_EN(1'b0), .TX_DATA(8'h00), .BP_WR(1'b0), .BP_WR_DATA(2'h0),
		.BLOCK_PROTECT(), .PROT_BASE(), .PROT_ANY(),
		.WRITE_BUSY(1'b0), .SELECTED(sel2), .HOLDING(hold2), .STANDBY());
	sei_link_properties sei_link_properties_inst (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .sclk(link.sclk), .mosi(link.mosi),
		.cs_n(link.cs_n), .hold_n(link.hold_n), .wp_n(link.wp_n),
		.q(link.q), .q_oe_n(link.q_oe_n));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(negedge clk_sys) begin
		if (rx_valid === 1'b1) begin
			rxq.push_back({rx_first, rx_data});
		end
		if (rx2_valid === 1'b1) begin
			rx2_cnt++;
		end
	end

	// ********************************
	// Checking and closing
	// ********************************
	task automatic chk_b(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_v(input logic [16:0] got, input logic [16:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ********************************
	// Master end transfers
	// ********************************
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] rsp);
		cmd_data = d;
		cmd_last = last;
		cmd_valid = 1'b1;
		for (int k = 0; k < 50 && cmd_ready !== 1'b1; k++) begin
			@(negedge clk_sys);
		end
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		for (int k = 0; k < 300 && rsp_valid !== 1'b1; k++) begin
			@(negedge clk_sys);
		end
		rsp = rsp_data;
	endtask

	task automatic wait_idle();
		for (int k = 0; k < 400 && busy !== 1'b0; k++) begin
			@(negedge clk_sys);
		end
		repeat (4) @(negedge clk_sys);
	endtask

	// Instruction byte then a read byte; the memory answers only in the second.
	task automatic pair_rd(input logic pol, input logic en, input logic [7:0] tx,
		input logic [7:0] b0, input logic [7:0] b1);
		logic [7:0] r;
		cpol_1 = pol;
		tx_en = en;
		tx_data = tx;
		repeat (4) @(negedge clk_sys);
		chk_b(link.sclk, pol);
		xfer(b0, 1'b0, r);
		chk_v(17'(r), 17'h000FF);
		xfer(b1, 1'b1, r);
		chk_v(17'(r), en ? 17'(tx) : 17'h000FF);
		wait_idle();
		chk_v(17'(rxq.pop_front()), {8'h00, 1'b1, b0});
		chk_v(17'(rxq.pop_front()), {8'h00, 1'b0, b1});
		chk_b(link.q_oe_n, 1'b1);
		chk_b(standby, 1'b1);
	endtask

	task automatic s_pause();
		logic [7:0] r;
		tx_en = 1'b1;
		tx_data = 8'hC3;
		xfer(8'h0B, 1'b0, r);
		@(negedge clk_sys);
		hold_req = 1'b1;
		for (int k = 0; k < 30 && holding !== 1'b1; k++) begin
			@(negedge clk_sys);
		end
		chk_b(holding, 1'b1);
		chk_b(link.q_oe_n, 1'b1);
		chk_b(selected, 1'b1);
		chk_b(standby, 1'b0);
		chk_b(cmd_ready, 1'b0);
		repeat (8) @(negedge clk_sys);
		chk_b(link.q_oe_n, 1'b1);
		hold_req = 1'b0;
		for (int k = 0; k < 30 && holding !== 1'b0; k++) begin
			@(negedge clk_sys);
		end
		xfer(8'hE7, 1'b1, r);
		chk_v(17'(r), 17'h000C3);
		wait_idle();
		chk_v(17'(rxq.pop_front()), 17'h0010B);
		chk_v(17'(rxq.pop_front()), 17'h000E7);
	endtask

	task automatic s_standby();
		chk_b(standby, 1'b1);
		write_busy = 1'b1;
		@(negedge clk_sys);
		chk_b(standby, 1'b0);
		write_busy = 1'b0;
		@(negedge clk_sys);
	endtask

	task automatic bp_put(input logic [1:0] v);
		bp_wr = 1'b1;
		bp_wr_data = v;
		@(negedge clk_sys);
		bp_wr = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask

	task automatic s_protect();
		logic [16:0] base [4] = '{17'h00000, SEI_PROT_QUARTER, SEI_PROT_HALF, SEI_PROT_WHOLE};
		for (int i = 0; i < 4; i++) begin
			bp_put(2'(i));
			chk_v({15'h0, block_protect}, 17'(i));
			chk_v(prot_base, base[i]);
			chk_b(prot_any, i != 0);
		end
		wp_level = 1'b0;
		repeat (6) @(negedge clk_sys);
		chk_b(link.wp_n, 1'b0);
		bp_put(2'h1);
		chk_v({15'h0, block_protect}, 17'h00003);
		wp_level = 1'b1;
		repeat (6) @(negedge clk_sys);
		bp_put(2'h0);
		chk_v({15'h0, block_protect}, 17'h00000);
	endtask

	// ********************************
	// Hand-driven link to the second memory end
	// ********************************
	task automatic raw_bits(input logic [7:0] b, input int hi, input int lo);
		for (int i = hi; i >= lo; i--) begin
			link_b.mosi = b[i];
			#62.5;
			link_b.sclk = 1'b1;
			#62.5;
			link_b.sclk = 1'b0;
		end
	endtask

	task automatic s_raw();
		@(negedge clk_sys);
		#2;
		raw_bits(8'hFF, 7, 0);
		#250;
		chk_b(sel2, 1'b0);
		chk_v(17'(rx2_cnt), 17'h00000);
		link_b.cs_n = 1'b1;
		#250;
		link_b.cs_n = 1'b0;
		#250;
		raw_bits(8'h3C, 7, 4);
		link_b.hold_n = 1'b0;
		#250;
		chk_b(hold2, 1'b1);
		chk_b(link_b.q_oe_n, 1'b1);
		raw_bits(8'h00, 1, 0);
		link_b.hold_n = 1'b1;
		#250;
		raw_bits(8'h3C, 3, 0);
		#250;
		chk_v(17'(rx2_data), 17'h0003C);
		raw_bits(8'hFF, 7, 5);
		link_b.hold_n = 1'b0;
		#250;
		link_b.cs_n = 1'b1;
		#250;
		chk_b(hold2, 1'b0);
		link_b.hold_n = 1'b1;
		link_b.cs_n = 1'b0;
		#250;
		raw_bits(8'h96, 7, 0);
		#250;
		chk_v(17'(rx2_data), 17'h00096);
		chk_v(17'(rx2_cnt), 17'h00002);
		link_b.cs_n = 1'b1;
	endtask

	initial begin
		#500000;
		error_cnt++;
		final_report();
	end

	initial begin
		error_cnt = 0;
		n_checks = 0;
		rx2_cnt = 0;
		rst_b = 1'b0;
		{cpol_1, hold_req, cmd_valid, cmd_last, tx_en, bp_wr, write_busy} = 7'h00;
		wp_level = 1'b1;
		cmd_data = 8'h00;
		tx_data = 8'h00;
		bp_wr_data = 2'h0;
		{link_b.sclk, link_b.mosi, link_b.cs_n} = 3'h0;
		{link_b.hold_n, link_b.wp_n} = 2'h3;
		repeat (8) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (4) @(negedge clk_sys);
		s_standby();
		pair_rd(1'b0, 1'b1, 8'hA5, 8'h01, 8'h80);
		pair_rd(1'b1, 1'b1, 8'h5A, 8'h03, 8'hC1);
		pair_rd(1'b0, 1'b0, 8'h3C, 8'h7E, 8'h02);
		s_pause();
		s_protect();
		s_raw();
		final_report();
	end
endmodule
